// ---- logic/saead_request_handler.sv ----
module saead_request_handler (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // negotiated features
   input  wire logic        cipher_stateless_en,
   input  wire logic        aead_stateless_en,
   // request header and fixed parameters
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [31:0] req_opcode,
   input  wire logic [31:0] req_flag,
   input  wire logic [63:0] req_session_id,
   input  wire logic [31:0] req_op_type,
   input  wire logic        req_ccm,
   input  wire logic [31:0] req_key_len,
   input  wire logic [31:0] req_auth_key_len,
   input  wire logic [31:0] req_iv_len,
   input  wire logic [31:0] req_src_len,
   input  wire logic [31:0] req_dst_len,
   input  wire logic [31:0] req_aad_len,
   input  wire logic [31:0] req_hash_len,
   input  wire logic [31:0] req_tag_len,
   // session and algorithm lookup
   output logic [63:0]      sess_id,
   input  wire logic        sess_known,
   input  wire logic        alg_supported,
   // request source bytes
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [7:0]  in_data,
   // engine control
   output logic             eng_start,
   output logic [1:0]       eng_kind,
   output logic             eng_decrypt,
   output logic             eng_session,
   output logic             eng_ccm,
   input  wire logic        eng_done,
   input  wire logic        eng_error,
   input  wire logic        eng_auth_fail,
   // engine input bytes
   output logic             eng_in_valid,
   input  wire logic        eng_in_ready,
   output logic [7:0]       eng_in_data,
   output logic [2:0]       eng_in_field,
   // engine result bytes
   input  wire logic        eng_res_valid,
   output logic             eng_res_ready,
   input  wire logic [7:0]  eng_res_data,
   // request write port
   output logic             wr_valid,
   input  wire logic        wr_ready,
   output logic [1:0]       wr_area,
   output logic [31:0]      wr_offset,
   output logic [7:0]       wr_data,
   // completion
   output logic             cpl_valid,
   output logic [7:0]       cpl_status
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] pick(input logic [7:0] mask, input logic [2:0] from);
      logic [2:0] r;
      logic       found;
      r     = saead_pkg::PH_NONE;
      found = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (!found && (3'(i) >= from) && mask[i]) begin
            r     = 3'(i);
            found = 1'b1;
         end
      end
      return r;
   endfunction

   saead_pkg::saead_state_t state, next_state;
   logic [31:0] opcode, flag, op_type, key_len, akey_len;
   logic [31:0] iv_len, src_len, dst_len, aad_len, hash_len, tag_len;
   logic        ccm, stateless;
   logic [7:0]  stat, chk_status;
   logic [1:0]  kind;
   logic        decrypt, session, opc_ok, iv_ok, done_seen, go, run_done;
   logic [32:0] need_dst;
   logic [31:0] fl [8];
   logic [31:0] dl [8];
   logic [7:0]  fmask, dmask;
   logic [2:0]  feed_ph, next_feed_ph, drain_ph, next_drain_ph;
   logic        feed_active, feed_last, feed_step, feed_load;
   logic        drain_active, drain_last, drain_step, drain_load;
   logic [31:0] drain_off;

   // ----------------------------------------------------------------
   // request capture
   // ----------------------------------------------------------------
   assign req_ready = (state == saead_pkg::SAEAD_IDLE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         opcode <= 32'h0; flag <= 32'h0; op_type <= 32'h0; key_len <= 32'h0;
         akey_len <= 32'h0; iv_len <= 32'h0; src_len <= 32'h0; dst_len <= 32'h0;
         aad_len <= 32'h0; hash_len <= 32'h0; tag_len <= 32'h0; ccm <= 1'b0;
         sess_id <= 64'h0;
      end else if (req_valid && req_ready) begin
         opcode <= req_opcode; flag <= req_flag; op_type <= req_op_type;
         key_len <= req_key_len; akey_len <= req_auth_key_len;
         iv_len <= req_iv_len; src_len <= req_src_len; dst_len <= req_dst_len;
         aad_len <= req_aad_len; hash_len <= req_hash_len; tag_len <= req_tag_len;
         ccm <= req_ccm;
         sess_id <= req_session_id;
      end
   end

   // ----------------------------------------------------------------
   // decode and checks
   // ----------------------------------------------------------------
   always_comb begin
      opc_ok  = 1'b1;
      decrypt = (opcode == saead_pkg::OPC_CIPHER_DEC) || (opcode == saead_pkg::OPC_AEAD_DEC);
      kind    = saead_pkg::KIND_CIPHER;
      // the request body layout follows the opcode first
      if ((opcode == saead_pkg::OPC_AEAD_ENC) || (opcode == saead_pkg::OPC_AEAD_DEC)) begin
         kind = saead_pkg::KIND_AEAD;
      end else if ((opcode == saead_pkg::OPC_CIPHER_ENC) ||
                   (opcode == saead_pkg::OPC_CIPHER_DEC)) begin
         if (op_type == saead_pkg::SYM_OP_CHAIN) begin
            kind = saead_pkg::KIND_CHAIN;
         end else if (op_type != saead_pkg::SYM_OP_CIPHER) begin
            opc_ok = 1'b0;
         end
      end else begin
         opc_ok = 1'b0;
      end
      // flag only matters once stateless service is negotiated
      stateless = ((kind == saead_pkg::KIND_AEAD) ? aead_stateless_en : cipher_stateless_en)
                  && (flag != saead_pkg::FLAG_SESSION_MODE);
      session   = !stateless;
      if (ccm) begin
         iv_ok = (iv_len >= saead_pkg::CCM_NONCE_MIN) && (iv_len <= saead_pkg::CCM_NONCE_MAX);
      end else begin
         iv_ok = (iv_len == saead_pkg::GCM_IV_SHORT) || (iv_len == saead_pkg::GCM_IV_J0);
      end
      need_dst = {1'b0, src_len} + {1'b0, ((kind == saead_pkg::KIND_AEAD) && !decrypt) ?
                                           tag_len : 32'h0};
      // priority: unsupported opcode, bad session, unsupported algorithm, other
      if (!opc_ok) begin
         chk_status = saead_pkg::ST_NOTSUPP;
      end else if (session && !sess_known) begin
         chk_status = saead_pkg::ST_INVSESS;
      end else if (!alg_supported) begin
         chk_status = saead_pkg::ST_NOTSUPP;
      end else if ((kind == saead_pkg::KIND_AEAD) && !iv_ok) begin
         chk_status = saead_pkg::ST_ERR;
      end else if (need_dst > {1'b0, dst_len}) begin
         chk_status = saead_pkg::ST_ERR;
      end else begin
         chk_status = saead_pkg::ST_OK;
      end
   end

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   assign go       = (state == saead_pkg::SAEAD_CHECK) && (chk_status == saead_pkg::ST_OK);
   assign run_done = done_seen && !eng_in_valid && !wr_valid &&
                     (((feed_ph == saead_pkg::PH_NONE) && (drain_ph == saead_pkg::PH_NONE))
                      || (stat != saead_pkg::ST_OK));

   always_comb begin
      next_state = state;
      case (state)
         saead_pkg::SAEAD_IDLE:   if (req_valid) next_state = saead_pkg::SAEAD_CHECK;
         saead_pkg::SAEAD_CHECK:  next_state = go ? saead_pkg::SAEAD_RUN : saead_pkg::SAEAD_STATUS;
         saead_pkg::SAEAD_RUN:    if (run_done) next_state = saead_pkg::SAEAD_STATUS;
         saead_pkg::SAEAD_STATUS: next_state = saead_pkg::SAEAD_IDLE;
         default:                 next_state = saead_pkg::SAEAD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= saead_pkg::SAEAD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // status and engine control
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stat <= saead_pkg::ST_OK;
         done_seen <= 1'b0;
      end else if (state == saead_pkg::SAEAD_CHECK) begin
         stat <= chk_status;
         done_seen <= 1'b0;
      end else if ((state == saead_pkg::SAEAD_RUN) && eng_done) begin
         done_seen <= 1'b1;
         if (eng_error) begin
            stat <= saead_pkg::ST_ERR;
         end else if ((eng_kind == saead_pkg::KIND_AEAD) && eng_decrypt && eng_auth_fail) begin
            stat <= saead_pkg::ST_BADMSG;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         eng_start <= 1'b0; eng_kind <= saead_pkg::KIND_CIPHER;
         eng_decrypt <= 1'b0; eng_session <= 1'b0; eng_ccm <= 1'b0;
      end else begin
         eng_start <= go;
         if (state == saead_pkg::SAEAD_CHECK) begin
            eng_kind <= kind; eng_decrypt <= decrypt;
            eng_session <= session; eng_ccm <= ccm;
         end
      end
   end

   // completion only after the write stage has emptied
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cpl_valid  <= 1'b0;
         cpl_status <= saead_pkg::ST_OK;
      end else begin
         cpl_valid <= (state == saead_pkg::SAEAD_STATUS);
         if (state == saead_pkg::SAEAD_STATUS) cpl_status <= stat;
      end
   end

   // ----------------------------------------------------------------
   // source phases: key, auth key, iv, aad (stateless chain), src, aad
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 8; i++) fl[i] = 32'h0;
      fl[0] = stateless ? key_len : 32'h0;
      fl[1] = (stateless && (kind == saead_pkg::KIND_CHAIN)) ? akey_len : 32'h0;
      // aead always carries the full iv area, ccm byte 0 included
      fl[2] = (kind == saead_pkg::KIND_AEAD) ? saead_pkg::AEAD_IV_AREA : iv_len;
      fl[3] = (stateless && (kind == saead_pkg::KIND_CHAIN)) ? aad_len : 32'h0;
      fl[4] = src_len;
      fl[5] = ((kind != saead_pkg::KIND_CIPHER) && !fl[3][31] && (fl[3] == 32'h0)) ?
              aad_len : 32'h0;
      // zero-length fields never open a phase
      for (int i = 0; i < 8; i++) fmask[i] = (fl[i] != 32'h0);
   end

   assign feed_active  = (state == saead_pkg::SAEAD_RUN) && (feed_ph != saead_pkg::PH_NONE)
                         && (stat == saead_pkg::ST_OK);
   assign in_ready     = feed_active && (!eng_in_valid || eng_in_ready);
   assign feed_step    = in_valid && in_ready;
   assign next_feed_ph = go ? pick(fmask, 3'h0) : pick(fmask, 3'(feed_ph + 3'h1));
   assign feed_load    = go || (feed_step && feed_last);

   saead_span u_feed (
      .clk    (clk),
      .resetn (resetn),
      .load   (feed_load),
      .len    (fl[next_feed_ph]),
      .step   (feed_step),
      .active (),
      .last   (feed_last)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         feed_ph <= saead_pkg::PH_NONE;
      end else if (feed_load) begin
         feed_ph <= next_feed_ph;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         eng_in_valid <= 1'b0;
         eng_in_data  <= 8'h00;
         eng_in_field <= saead_pkg::FIELD_KEY;
      end else if (feed_step) begin
         eng_in_valid <= 1'b1;
         eng_in_data  <= in_data;
         case (feed_ph)
            3'h0:    eng_in_field <= saead_pkg::FIELD_KEY;
            3'h1:    eng_in_field <= saead_pkg::FIELD_AKEY;
            3'h2:    eng_in_field <= saead_pkg::FIELD_IV;
            3'h4:    eng_in_field <= saead_pkg::FIELD_SRC;
            default: eng_in_field <= saead_pkg::FIELD_AAD;
         endcase
      end else if (eng_in_ready) begin
         eng_in_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // result phases: dst data, hash, tag, iv write-back
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 8; i++) dl[i] = 32'h0;
      dl[0] = src_len;
      dl[1] = (kind == saead_pkg::KIND_CHAIN) ? hash_len : 32'h0;
      dl[2] = ((kind == saead_pkg::KIND_AEAD) && !decrypt) ? tag_len : 32'h0;
      dl[3] = (kind == saead_pkg::KIND_AEAD) ? saead_pkg::AEAD_IV_AREA : 32'h0;
      for (int i = 0; i < 8; i++) dmask[i] = (dl[i] != 32'h0);
   end

   assign drain_active  = (state == saead_pkg::SAEAD_RUN) && (drain_ph != saead_pkg::PH_NONE)
                          && (stat == saead_pkg::ST_OK);
   assign eng_res_ready = drain_active && (!wr_valid || wr_ready);
   assign drain_step    = eng_res_valid && eng_res_ready;
   assign next_drain_ph = go ? pick(dmask, 3'h0) : pick(dmask, 3'(drain_ph + 3'h1));
   assign drain_load    = go || (drain_step && drain_last);

   saead_span u_drain (
      .clk    (clk),
      .resetn (resetn),
      .load   (drain_load),
      .len    (dl[next_drain_ph]),
      .step   (drain_step),
      .active (),
      .last   (drain_last)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         drain_ph  <= saead_pkg::PH_NONE;
         drain_off <= 32'h0;
      end else if (drain_load) begin
         drain_ph <= next_drain_ph;
         // tag continues the dst offset right after the cipher bytes
         if (go || (next_drain_ph != 3'h2)) drain_off <= 32'h0;
         else drain_off <= drain_off + 32'h1;
      end else if (drain_step) begin
         drain_off <= drain_off + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_valid  <= 1'b0;
         wr_area   <= saead_pkg::AREA_DST;
         wr_offset <= 32'h0;
         wr_data   <= 8'h00;
      end else if (drain_step) begin
         wr_valid  <= 1'b1;
         wr_offset <= drain_off;
         wr_data   <= eng_res_data;
         case (drain_ph)
            3'h1:    wr_area <= saead_pkg::AREA_HASH;
            3'h3:    wr_area <= saead_pkg::AREA_IV;
            default: wr_area <= saead_pkg::AREA_DST;
         endcase
      end else if (wr_ready) begin
         wr_valid <= 1'b0;
      end
   end

endmodule

// ---- logic/saead_pkg.sv ----
package saead_pkg;

   // ----------------------------------------------------------------
   // header codes (plain defaults)
   // ----------------------------------------------------------------
   localparam logic [31:0] OPC_CIPHER_ENC    = 32'h00000001;
   localparam logic [31:0] OPC_CIPHER_DEC    = 32'h00000002;
   localparam logic [31:0] OPC_AEAD_ENC      = 32'h00000003;
   localparam logic [31:0] OPC_AEAD_DEC      = 32'h00000004;
   localparam logic [31:0] SYM_OP_CIPHER     = 32'h00000001;
   localparam logic [31:0] SYM_OP_CHAIN      = 32'h00000002;
   localparam logic [31:0] FLAG_SESSION_MODE = 32'h00000001;

   // ----------------------------------------------------------------
   // completion status codes (plain defaults)
   // ----------------------------------------------------------------
   localparam logic [7:0] ST_OK      = 8'h00;
   localparam logic [7:0] ST_ERR     = 8'h01;
   localparam logic [7:0] ST_BADMSG  = 8'h02;
   localparam logic [7:0] ST_NOTSUPP = 8'h03;
   localparam logic [7:0] ST_INVSESS = 8'h04;

   // ----------------------------------------------------------------
   // iv limits and sizes
   // ----------------------------------------------------------------
   localparam logic [31:0] GCM_IV_SHORT  = 32'h0000000c;
   localparam logic [31:0] GCM_IV_J0     = 32'h00000010;
   localparam logic [31:0] CCM_NONCE_MIN = 32'h00000007;
   localparam logic [31:0] CCM_NONCE_MAX = 32'h0000000d;
   localparam logic [31:0] AEAD_IV_AREA  = 32'h00000010;
   localparam logic [31:0] SYM_FLF_BYTES = 32'h00000028;

   // ----------------------------------------------------------------
   // request kinds, source fields, write areas
   // ----------------------------------------------------------------
   localparam logic [1:0] KIND_CIPHER = 2'h0;
   localparam logic [1:0] KIND_CHAIN  = 2'h1;
   localparam logic [1:0] KIND_AEAD   = 2'h2;

   localparam logic [2:0] FIELD_KEY  = 3'h0;
   localparam logic [2:0] FIELD_AKEY = 3'h1;
   localparam logic [2:0] FIELD_IV   = 3'h2;
   localparam logic [2:0] FIELD_AAD  = 3'h3;
   localparam logic [2:0] FIELD_SRC  = 3'h4;

   localparam logic [1:0] AREA_DST  = 2'h0;
   localparam logic [1:0] AREA_HASH = 2'h1;
   localparam logic [1:0] AREA_IV   = 2'h2;

   // phase index meaning "no phase left"
   localparam logic [2:0] PH_NONE = 3'h6;

   typedef enum logic [3:0] {
      SAEAD_IDLE   = 4'h1,
      SAEAD_CHECK  = 4'h2,
      SAEAD_RUN    = 4'h4,
      SAEAD_STATUS = 4'h8
   } saead_state_t;

endpackage

// ---- logic/saead_span.sv ----
module saead_span (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // control
   input  wire logic        load,
   input  wire logic [31:0] len,
   input  wire logic        step,
   // state
   output logic             active,
   output logic             last
);

   logic [31:0] remaining;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         remaining <= 32'h00000000;
      end else if (load) begin
         remaining <= len;
      end else if (step && active) begin
         remaining <= remaining - 32'h00000001;
      end
   end

   assign active = (remaining != 32'h00000000);
   assign last   = (remaining == 32'h00000001);

endmodule

// ---- test/saead_checker.sv ----
module saead_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // request side
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [31:0] req_opcode,
   input wire logic [31:0] req_op_type,
   input wire logic [31:0] req_flag,
   input wire logic [31:0] req_aad_len,
   input wire logic        sess_known,
   // engine side
   input wire logic        eng_start,
   input wire logic        eng_done,
   input wire logic        eng_error,
   input wire logic        eng_auth_fail,
   input wire logic        eng_decrypt,
   input wire logic [1:0]  eng_kind,
   input wire logic        eng_in_valid,
   input wire logic        eng_in_ready,
   input wire logic [7:0]  eng_in_data,
   input wire logic [2:0]  eng_in_field,
   // writes and completion
   input wire logic        wr_valid,
   input wire logic        wr_ready,
   input wire logic [31:0] wr_offset,
   input wire logic [7:0]  wr_data,
   input wire logic        cpl_valid,
   input wire logic [7:0]  cpl_status
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic        acc;
   logic [31:0] aad_q;
   assign acc = req_valid && req_ready;
   // aad length of the request in flight
   always_ff @(posedge clk) begin
      if (!resetn) aad_q <= 32'h0;
      else if (acc) aad_q <= req_aad_len;
   end
   property p_bad_op;
      acc && (req_opcode == 32'h0 || req_opcode > saead_pkg::OPC_AEAD_DEC)
         |-> ##3 cpl_valid && cpl_status == saead_pkg::ST_NOTSUPP;
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("bad opcode not refused");
   property p_invsess;
      acc && req_opcode == saead_pkg::OPC_CIPHER_ENC && req_op_type == saead_pkg::SYM_OP_CIPHER
         && req_flag == saead_pkg::FLAG_SESSION_MODE ##1 !sess_known
         |-> ##2 cpl_valid && cpl_status == saead_pkg::ST_INVSESS;
   endproperty
   a_invsess: assert property (p_invsess) else $error("unknown session accepted");
   property p_start;
      eng_start |-> $past(acc, 2);
   endproperty
   a_start: assert property (p_start) else $error("engine start off its slot");
   property p_cpl_pulse;
      cpl_valid |=> !cpl_valid;
   endproperty
   a_cpl_pulse: assert property (p_cpl_pulse) else $error("completion not a pulse");
   property p_cpl_last;
      cpl_valid |-> !wr_valid && !$past(wr_valid) && !eng_in_valid;
   endproperty
   a_cpl_last: assert property (p_cpl_last) else $error("status before data");
   property p_wr_hold;
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_offset) && $stable(wr_data);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write dropped while stalled");
   property p_in_hold;
      eng_in_valid && !eng_in_ready |=> eng_in_valid && $stable(eng_in_data)
         && $stable(eng_in_field);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("engine byte dropped");
   property p_aad;
      eng_in_valid && eng_in_field == saead_pkg::FIELD_AAD |-> aad_q != 32'h0;
   endproperty
   a_aad: assert property (p_aad) else $error("aad parsed with zero length");
   property p_badmsg;
      eng_done && eng_auth_fail && !eng_error && eng_decrypt
         && eng_kind == saead_pkg::KIND_AEAD
         |-> ##[1:64] cpl_valid && cpl_status == saead_pkg::ST_BADMSG;
   endproperty
   a_badmsg: assert property (p_badmsg) else $error("tag failure not reported");
endmodule

bind saead_request_handler saead_checker chk (.*);

// ---- test/saead_engine_model.sv ----
module saead_engine_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // engine handshake
   input  wire logic       eng_start,
   input  wire logic       eng_in_valid,
   output logic            eng_in_ready,
   output logic            eng_res_valid,
   input  wire logic       eng_res_ready,
   output logic [7:0]      eng_res_data,
   output logic            eng_done,
   output logic            eng_error,
   output logic            eng_auth_fail,
   // test controls
   input  wire logic [7:0] res_n,
   input  wire logic       slow,
   input  wire logic       bad_tag,
   input  wire logic       fault
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left;
   logic       busy;
   assign eng_error = fault;
   assign eng_auth_fail = bad_tag;
   // data moves whenever not held, so stale bytes never look valid
   always @(posedge clk) begin
      eng_done <= 1'b0;
      eng_in_ready <= slow ? ~eng_in_ready : 1'b1;
      if (!eng_res_valid || eng_res_ready) eng_res_data <= eng_res_data + 8'h3b;
      if (!resetn) begin
         busy <= 1'b0;
         eng_res_valid <= 1'b0;
         eng_in_ready <= 1'b0;
         eng_res_data <= 8'h00;
         left <= 8'h00;
      end else if (eng_start) begin
         busy <= 1'b1;
         left <= res_n;
         eng_res_valid <= res_n != 8'h00;
      end else if (busy && !eng_res_valid) begin
         busy <= 1'b0;
         eng_done <= 1'b1;
      end else if (eng_res_valid && eng_res_ready) begin
         left <= left - 8'h01;
         eng_res_valid <= left > 8'h01;
      end
   end
endmodule

// ---- test/saead_request_handler_test.sv ----
module saead_request_handler_test;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
      $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
   logic clk = 0, resetn = 0, cipher_stateless_en = 0, aead_stateless_en = 0, req_valid = 0;
   logic req_ccm = 0, sess_known = 0, alg_supported = 0, in_valid = 0, wr_ready = 0;
   logic slow = 0, bad_tag = 0, fault = 0, hs;
   logic req_ready, in_ready, eng_start, eng_decrypt, eng_session, eng_ccm, eng_done;
   logic eng_error, eng_auth_fail, eng_in_valid, eng_in_ready, eng_res_valid, eng_res_ready;
   logic wr_valid, cpl_valid;
   logic [31:0] req_opcode = 0, req_flag = 0, req_op_type = 0, req_key_len = 0;
   logic [31:0] req_auth_key_len = 0, req_iv_len = 0, req_src_len = 0, req_dst_len = 0;
   logic [31:0] req_aad_len = 0, req_hash_len = 0, req_tag_len = 0, wr_offset, last_dst;
   logic [63:0] req_session_id = 64'h0000_0000_0000_0005, sess_id;
   logic [7:0]  in_data = 0, res_n = 0, eng_in_data, eng_res_data, wr_data, cpl_status, got;
   logic [1:0]  eng_kind, wr_area;
   logic [2:0]  eng_in_field;
   int failures = 0, cmp_count = 0, n_dst, n_hash, n_iv;
   saead_request_handler uut (.*);
   saead_engine_model eng (.*);
   always #25 clk = ~clk;
   always @(posedge clk) wr_ready <= slow ? ~wr_ready : 1'b1;
   always @(negedge clk) begin
      if (wr_valid && wr_ready) begin
         if (wr_area == saead_pkg::AREA_DST) begin
            n_dst++;
            last_dst = wr_offset;
         end else if (wr_area == saead_pkg::AREA_HASH) n_hash++;
         else n_iv++;
      end
   end
   task automatic finish_test;
      $display("compares=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one request; lengths in bytes, expected status st
   task automatic go(input logic [7:0] op, ty, fl, ivl, src, dst, aad, hsh, tag, key, st);
      logic [31:0] o;
      logic        ae, ch;
      int          nin, fed, i;
      o = 32'(op);
      ae = o == saead_pkg::OPC_AEAD_ENC || o == saead_pkg::OPC_AEAD_DEC;
      ch = !ae && 32'(ty) == saead_pkg::SYM_OP_CHAIN;
      nin = key + (ch ? key : 0) + (ae ? 16 : ivl) + src + (ae || ch ? aad : 0);
      n_dst = 0; n_hash = 0; n_iv = 0; last_dst = 0; got = 8'hee; fed = 0;
      res_n <= src + (ch ? hsh : 8'h0) + (o == saead_pkg::OPC_AEAD_ENC ? tag : 8'h0)
               + (ae ? 8'h10 : 8'h0);
      {req_opcode, req_op_type, req_flag, req_iv_len} <= {o, 32'(ty), 32'(fl), 32'(ivl)};
      {req_src_len, req_dst_len, req_aad_len} <= {32'(src), 32'(dst), 32'(aad)};
      // parsed fields only: unused fixed-area bytes never reach the block
      {req_hash_len, req_tag_len, req_key_len} <= {32'(hsh), 32'(tag), 32'(key)};
      req_auth_key_len <= ch ? 32'(key) : 32'h0;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      in_valid <= nin != 0;
      in_data <= 8'h00;
      for (i = 0; i < 3000 && got === 8'hee; i++) begin
         @(negedge clk);
         hs = in_valid && in_ready;
         if (cpl_valid) got = cpl_status;
         @(posedge clk);
         if (hs) fed++;
         in_valid <= fed < nin;
         in_data <= fed[7:0];
      end
      `CHK(got, st)
      `CHK(sess_id, req_session_id)
      `CHK(eng_session, fl != 8'h0 || !(ae ? aead_stateless_en : cipher_stateless_en))
      `CHK(eng_ccm, req_ccm)
      if (st == saead_pkg::ST_OK) begin
         `CHK(n_dst, src + (o == saead_pkg::OPC_AEAD_ENC ? tag : 0))
         `CHK(last_dst, 32'(n_dst - 1))
         `CHK(n_hash, ch ? hsh : 0)
         `CHK(n_iv, ae ? 16 : 0)
      end
      $display("test done op=%h iv=%h status=%h", op, ivl, got);
   endtask
   initial begin
      #(50 * 40000);
      failures++;
      finish_test;
   end
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      sess_known <= 1'b1;
      alg_supported <= 1'b1;
      go(8'h9, 8'h1, 8'h1, 8'h2, 8'h3, 8'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h3);
      go(8'h1, 8'h3, 8'h1, 8'h2, 8'h3, 8'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h3);
      alg_supported <= 1'b0;
      go(8'h1, 8'h1, 8'h1, 8'h2, 8'h3, 8'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h3);
      alg_supported <= 1'b1;
      sess_known <= 1'b0;
      go(8'h1, 8'h1, 8'h1, 8'h2, 8'h3, 8'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h4);
      cipher_stateless_en <= 1'b1;
      go(8'h2, 8'h1, 8'h0, 8'h1, 8'h2, 8'h2, 8'h0, 8'h0, 8'h0, 8'h4, 8'h0);
      sess_known <= 1'b1;
      slow <= 1'b1;
      go(8'h1, 8'h1, 8'h1, 8'h2, 8'h3, 8'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0);
      go(8'h1, 8'h2, 8'h1, 8'h1, 8'h2, 8'h2, 8'h2, 8'h4, 8'h0, 8'h0, 8'h0);
      go(8'h2, 8'h2, 8'h1, 8'h1, 8'h2, 8'h2, 8'h0, 8'h4, 8'h0, 8'h0, 8'h0);
      go(8'h1, 8'h2, 8'h0, 8'h1, 8'h2, 8'h2, 8'h2, 8'h4, 8'h0, 8'h3, 8'h0);
      go(8'h1, 8'h1, 8'h1, 8'h2, 8'h3, 8'h2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1);
      fault <= 1'b1;
      go(8'h1, 8'h1, 8'h1, 8'h1, 8'h1, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1);
      fault <= 1'b0;
      go(8'h3, 8'h0, 8'h1, 8'hc, 8'h3, 8'h7, 8'h2, 8'h0, 8'h4, 8'h0, 8'h0);
      go(8'h3, 8'h0, 8'h1, 8'h10, 8'h3, 8'h7, 8'h0, 8'h0, 8'h4, 8'h0, 8'h0);
      go(8'h3, 8'h0, 8'h1, 8'hb, 8'h3, 8'h7, 8'h0, 8'h0, 8'h4, 8'h0, 8'h1);
      req_ccm <= 1'b1;
      for (int v = 6; v < 15; v++)
         go(8'h3, 8'h0, 8'h1, 8'(v), 8'h2, 8'h6, 8'h1, 8'h0, 8'h4, 8'h0,
            (32'(v) >= saead_pkg::CCM_NONCE_MIN && 32'(v) <= saead_pkg::CCM_NONCE_MAX)
            ? saead_pkg::ST_OK : saead_pkg::ST_ERR);
      go(8'h3, 8'h0, 8'h1, 8'hd, 8'h3, 8'h6, 8'h0, 8'h0, 8'h4, 8'h0, 8'h1);
      go(8'h4, 8'h0, 8'h1, 8'hd, 8'h3, 8'h3, 8'h1, 8'h0, 8'h4, 8'h0, 8'h0);
      bad_tag <= 1'b1;
      go(8'h4, 8'h0, 8'h1, 8'hd, 8'h3, 8'h3, 8'h1, 8'h0, 8'h4, 8'h0, 8'h2);
      bad_tag <= 1'b0;
      aead_stateless_en <= 1'b1;
      sess_known <= 1'b0;
      go(8'h3, 8'h0, 8'h0, 8'h7, 8'h2, 8'h6, 8'h0, 8'h0, 8'h4, 8'h4, 8'h0);
      finish_test;
   end
endmodule
